/* File: inc/hdks_cfg.svh */
// What this block does
// - Half protected first subfield: 64 data, 16 check
// - Half unprotected B-field: all 80+j bits encryptable
// - Half slot: checks and X-field never XORed
// - Half slot: two segments of 120+j bits
// - Control tail: segment 0..39 onto a8..a47
// - Half unprotected: segment 40.. onto b0..
// - Protected: segment 40..103 onto b0..b63 only
// - Half, j>0: segment 120.. onto b80..
// - Half slot pair totals 240+2j bits
// - Double slot: 8,40,16,800,4 bit fields
// - Double unprotected B-field: all 800 encryptable
// - Double protected subfields: 64 data, 16 check
// - Double slot: checks and X-field excluded
// - Double slot: two segments of 840 bits
// - Double unprotected: segment 40..839 onto b0..b799
// - Double protected: subfield k data gets segment 40+80k..
// - Double protected: segment 824..839 unused
// - Double slot pair totals 1680 bits
`ifndef HDKS_CFG_SVH
`define HDKS_CFG_SVH

// ****************************************
// Field layout, bit positions in the D-field
// ****************************************
`define HDKS_HDR_LEN      10'h008
`define HDKS_TAIL_FIRST   10'h008
`define HDKS_TAIL_LAST    10'h02f
`define HDKS_A_LEN        10'h040
`define HDKS_X_LEN        10'h004
`define HDKS_HALF_B_BASE  10'h050
`define HDKS_DOUBLE_B_LEN 10'h320
`define HDKS_SUB_LEN      7'h50
`define HDKS_SUB_DATA     7'h40

// ****************************************
// Key stream segment sizes
// ****************************************
`define HDKS_KS_TAIL_LEN  11'h028
`define HDKS_HALF_SEG     11'h078
`define HDKS_DOUBLE_SEG   11'h348

`endif

/* File: inc/hdks_pkg.sv */
package hdks_pkg;

  typedef enum logic [1:0] {
    HDKS_IDLE  = 2'b00,
    HDKS_FIELD = 2'b01,
    HDKS_FLUSH = 2'b10
  } hdks_state_t;

  typedef enum logic {
    HDKS_HALF   = 1'b0,
    HDKS_DOUBLE = 1'b1
  } hdks_slot_t;

endpackage

/* File: logic/hdks_bit_map.sv */
`timescale 1ns/1ps
`include "hdks_cfg.svh"

module hdks_bit_map
  import hdks_pkg::*;
#(
  parameter int POS_W = 10
) (
  pos,
  subOff,
  bLen,
  protectedFmt,
  tailIsCt,
  consumeKs,
  applyKs
);
  input  wire logic [POS_W-1:0] pos;
  input  wire logic [6:0]       subOff;
  input  wire logic [POS_W-1:0] bLen;
  input  wire logic             protectedFmt;
  input  wire logic             tailIsCt;
  output logic                  consumeKs;
  output logic                  applyKs;

  logic inTail;
  logic inB;
  logic checkBit;

  // ****************************************
  // Region decode
  // ****************************************
  assign inTail   = (pos >= `HDKS_TAIL_FIRST) && (pos <= `HDKS_TAIL_LAST);
  assign inB      = (pos >= `HDKS_A_LEN) && (pos < `HDKS_A_LEN + bLen);
  // Check bits still use up a segment bit so later subfields stay aligned
  // Half slot has one check field only; its bits 80 upward are all data
  assign checkBit = protectedFmt && (subOff >= `HDKS_SUB_DATA)
                    && ((bLen == `HDKS_DOUBLE_B_LEN)
                        || (pos < `HDKS_A_LEN + POS_W'(`HDKS_SUB_LEN)));

  // Tail and B bits always consume; segment index is one-to-one with position
  assign consumeKs = inTail || inB;
  always_comb begin
    applyKs = 1'b0;
    if (inTail) begin
      applyKs = tailIsCt;
    end else if (inB) begin
      applyKs = !checkBit;
    end
  end

endmodule

/* File: logic/hdks_xor_core.sv */
`timescale 1ns/1ps
`include "hdks_cfg.svh"

module hdks_xor_core
  import hdks_pkg::*;
#(
  parameter int POS_W = 10,
  parameter int J_W   = 7
) (
  clk_sys,
  sys_rst,
  frameStart,
  slotType,
  protectedFmt,
  tailIsCt,
  encryptOn,
  jLen,
  frameBusy,
  inBit,
  inValid,
  inReady,
  ksBit,
  ksValid,
  ksReady,
  outBit,
  outValid,
  outReady,
  outLast,
  fieldDone,
  pairSecond,
  ksUsed
);
  input  wire logic       clk_sys;
  input  wire logic       sys_rst;
  input  wire logic       frameStart;
  input  wire hdks_slot_t slotType;
  input  wire logic       protectedFmt;
  input  wire logic       tailIsCt;
  input  wire logic       encryptOn;
  input  wire logic [J_W-1:0] jLen;
  output logic            frameBusy;
  input  wire logic       inBit;
  input  wire logic       inValid;
  output logic            inReady;
  input  wire logic       ksBit;
  input  wire logic       ksValid;
  output logic            ksReady;
  output logic            outBit;
  output logic            outValid;
  input  wire logic       outReady;
  output logic            outLast;
  output logic            fieldDone;
  output logic            pairSecond;
  output logic [10:0]     ksUsed;

  hdks_state_t      state_r;
  hdks_state_t      state_nxt;
  logic             protected_r;
  logic             tailCt_r;
  logic             encrypt_r;
  logic [POS_W-1:0] bLen_r;
  logic [POS_W-1:0] bLen_nxt;
  logic [POS_W-1:0] lastPos_r;
  logic [POS_W-1:0] pos_r;
  logic [6:0]       subOff_r;
  logic             outBit_r;
  logic             outValid_r;
  logic             outLast_r;
  logic             fieldDone_r;
  logic             pairSecond_r;
  logic [10:0]      ksUsed_r;
  logic             consumeKs;
  logic             applyKs;
  logic             needKs;
  logic             outSpace;
  logic             fire;
  logic             lastBit;

  // ****************************************
  // Bit position decode
  // ****************************************
  hdks_bit_map #(
    .POS_W (POS_W)
  ) u_map (
    .pos          (pos_r),
    .subOff       (subOff_r),
    .bLen         (bLen_r),
    .protectedFmt (protected_r),
    .tailIsCt     (tailCt_r),
    .consumeKs    (consumeKs),
    .applyKs      (applyKs)
  );

  // ****************************************
  // Handshake
  // ****************************************
  // Clear mode never asks the generator for bits
  assign needKs   = encrypt_r && consumeKs;
  assign outSpace = !outValid_r || outReady;
  assign fire     = (state_r == HDKS_FIELD) && inValid && outSpace
                    && (!needKs || ksValid);
  assign inReady  = (state_r == HDKS_FIELD) && outSpace && (!needKs || ksValid);
  // Segment bit is taken together with its data bit, so none is lost or reused
  assign ksReady  = (state_r == HDKS_FIELD) && inValid && outSpace && needKs;
  assign lastBit  = (pos_r == lastPos_r);

  // Half slot B-field is 80+j bits, double slot fixed
  always_comb begin
    if (slotType == HDKS_DOUBLE) begin
      bLen_nxt = `HDKS_DOUBLE_B_LEN;
    end else begin
      bLen_nxt = `HDKS_HALF_B_BASE + POS_W'(jLen);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HDKS_IDLE: begin
        if (frameStart) begin
          state_nxt = HDKS_FIELD;
        end
      end
      HDKS_FIELD: begin
        if (fire && lastBit) begin
          state_nxt = HDKS_FLUSH;
        end
      end
      HDKS_FLUSH: begin
        // Wait for the last bit to leave before a new field is taken
        if (!outValid_r) begin
          state_nxt = HDKS_IDLE;
        end
      end
      default: begin
        state_nxt = HDKS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= HDKS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Field settings, held for the whole field
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      protected_r <= 1'b0;
      tailCt_r    <= 1'b0;
      encrypt_r   <= 1'b0;
      bLen_r      <= '0;
      lastPos_r   <= '0;
    end else if ((state_r == HDKS_IDLE) && frameStart) begin
      protected_r <= protectedFmt;
      tailCt_r    <= tailIsCt;
      encrypt_r   <= encryptOn;
      bLen_r      <= bLen_nxt;
      lastPos_r   <= `HDKS_A_LEN + bLen_nxt + `HDKS_X_LEN - POS_W'(1);
    end
  end

  // ****************************************
  // Position and subfield counters
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pos_r <= '0;
    end else if ((state_r == HDKS_IDLE) && frameStart) begin
      pos_r <= '0;
    end else if (fire) begin
      pos_r <= pos_r + POS_W'(1);
    end
  end

  // Offset inside each 80-bit subfield; also covers half slot bits 80 upward
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      subOff_r <= '0;
    end else if ((state_r == HDKS_IDLE) && frameStart) begin
      subOff_r <= '0;
    end else if (fire && (pos_r >= `HDKS_A_LEN)) begin
      if (subOff_r == `HDKS_SUB_LEN - 7'h01) begin
        subOff_r <= '0;
      end else begin
        subOff_r <= subOff_r + 7'h01;
      end
    end
  end

  // ****************************************
  // XOR and output register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      outValid_r <= 1'b0;
      outBit_r   <= 1'b0;
      outLast_r  <= 1'b0;
    end else if (fire) begin
      outValid_r <= 1'b1;
      outBit_r   <= inBit ^ (needKs && applyKs && ksBit);
      outLast_r  <= lastBit;
    end else if (outReady) begin
      outValid_r <= 1'b0;
      outLast_r  <= 1'b0;
    end
  end

  // ****************************************
  // Segment accounting
  // ****************************************
  // Counts segment bits taken in this field: 40+bLen when encrypting
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ksUsed_r <= '0;
    end else if ((state_r == HDKS_IDLE) && frameStart) begin
      ksUsed_r <= '0;
    end else if (fire && needKs) begin
      ksUsed_r <= ksUsed_r + 11'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fieldDone_r <= 1'b0;
    end else begin
      fieldDone_r <= fire && lastBit;
    end
  end

  // Two fields share one concatenated segment pair
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pairSecond_r <= 1'b0;
    end else if (fire && lastBit && encrypt_r) begin
      pairSecond_r <= !pairSecond_r;
    end else if (fire && lastBit) begin
      pairSecond_r <= 1'b0;
    end
  end

  assign frameBusy  = (state_r != HDKS_IDLE);
  assign outBit     = outBit_r;
  assign outValid   = outValid_r;
  assign outLast    = outLast_r;
  assign fieldDone  = fieldDone_r;
  assign pairSecond = pairSecond_r;
  assign ksUsed     = ksUsed_r;

endmodule

/* File: tb/hdks_xor_core_sva.sv */
`timescale 1ns/1ps
module hdks_xor_core_sva
  import hdks_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        frameStart,
  input wire hdks_slot_t  slotType,
  input wire logic        encryptOn,
  input wire logic [6:0]  jLen,
  input wire logic        frameBusy,
  input wire logic        inBit,
  input wire logic        inValid,
  input wire logic        inReady,
  input wire logic        ksValid,
  input wire logic        ksReady,
  input wire logic        outBit,
  input wire logic        fieldDone,
  input wire logic [10:0] ksUsed
);
  logic        encR;
  logic [10:0] segR;
  logic [10:0] nInR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    if (frameStart && !frameBusy) begin
      encR <= encryptOn;
      segR <= (slotType == HDKS_DOUBLE) ? 11'h348 : 11'h078 + 11'(jLen);
    end
  end
  // Field position of the next bit taken
  always_ff @(posedge clk_sys) begin
    if (frameStart && !frameBusy) nInR <= 11'h000;
    else if (inValid && inReady) nInR <= nInR + 11'h001;
  end
  clear_noks_a: assert property (frameBusy && !encR |-> !ksReady)
    else $error("key stream taken in clear mode");
  ks_order_a: assert property (ksValid && ksReady |->
    ksUsed == ((nInR >= 11'h040) ? nInR - 11'h018 : nInR - 11'h008))
    else $error("key stream index out of step with field position");
  ks_window_a: assert property (ksValid && ksReady |->
    (nInR >= 11'h008 && nInR < 11'h030) || (nInR >= 11'h040 && nInR < segR + 11'h018))
    else $error("key stream taken outside tail and B-field");
  used_cap_a: assert property (frameBusy |-> ksUsed <= segR)
    else $error("more key stream than one segment");
  used_full_a: assert property (fieldDone && encR |-> ksUsed == segR)
    else $error("segment not fully consumed");
  field_len_a: assert property (fieldDone |-> nInR == segR + 11'h01c)
    else $error("field length wrong");
  clear_pass_a: assert property (frameBusy && !encR && inValid && inReady
    |=> outBit == $past(inBit))
    else $error("clear bit altered");
  xfield_clear_a: assert property (frameBusy && inValid && inReady
    && nInR >= segR + 11'h018 |=> outBit == $past(inBit))
    else $error("X-field bit altered");
endmodule

/* File: tb/hdks_ks_source.sv */
`timescale 1ns/1ps
module hdks_ks_source (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic frameStart,
  input wire logic frameBusy,
  input wire logic ksReady,
  input wire logic slow,
  output logic     ksBit,
  output logic     ksValid
);
  logic [10:0] idxR;
  logic        gapR;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (frameStart && !frameBusy)) idxR <= 11'h000;
    else if (ksValid && ksReady) idxR <= idxR + 11'h001;
  end
  always_ff @(posedge clk_sys) gapR <= sys_rst ? 1'b0 : slow && !gapR;
  assign ksValid = !gapR;
  // Inverted bit during a gap, so a stale sample cannot match
  assign ksBit = gapR ^ idxR[0] ^ idxR[2] ^ idxR[5];
endmodule

/* File: tb/test_half_double_slot_keystream_xor.sv */
`timescale 1ns/1ps
module test_half_double_slot_keystream_xor import hdks_pkg::*;;
  logic       clk_sys = 0, sys_rst = 1, frameStart = 0, protectedFmt = 0;
  logic       tailIsCt = 0, encryptOn = 0, inBit = 0, inValid = 0;
  logic       outReady = 1, slow = 0;
  hdks_slot_t slotType = HDKS_HALF;
  logic [6:0] jLen = 7'h00;
  logic       frameBusy, inReady, ksBit, ksValid, ksReady;
  logic       outBit, outValid, outLast, fieldDone, pairSecond;
  logic [10:0] ksUsed;
  int         errors = 0, compares = 0, outIdx = 0, nLen = 0, nDone = 0;
  hdks_xor_core u_hdks_xor_core (.clk_sys, .sys_rst, .frameStart, .slotType,
    .protectedFmt, .tailIsCt, .encryptOn, .jLen, .frameBusy, .inBit, .inValid,
    .inReady, .ksBit, .ksValid, .ksReady, .outBit, .outValid, .outReady, .outLast,
    .fieldDone, .pairSecond, .ksUsed);
  hdks_ks_source u_hdks_ks_source (.clk_sys, .sys_rst, .frameStart, .frameBusy,
    .ksReady, .slow, .ksBit, .ksValid);
  initial forever #2 clk_sys = !clk_sys;
  always @(posedge clk_sys) outReady <= slow ? !outReady : 1'b1;
  task automatic check(input string what, input logic [10:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic pat(int p);
    return p[0] ^ p[3];
  endfunction
  function automatic logic expBit(int p);
    int s;
    s = (p >= 64) ? p - 24 : p - 8;
    if (!encryptOn || p < 8 || (p >= 48 && p < 64) || p >= nLen - 4) return pat(p);
    if (p < 48 && !tailIsCt) return pat(p);
    if (p >= 64 && protectedFmt && (p - 64) % 80 >= 64 && (nLen == 868 || p < 144))
      return pat(p);
    return pat(p) ^ s[0] ^ s[2] ^ s[5];
  endfunction
  always @(negedge clk_sys) begin
    if (fieldDone) nDone++;
    if (outValid && outReady) begin
      check("outBit", 11'(outBit), 11'(expBit(outIdx)));
      check("outLast", 11'(outLast), 11'(outIdx == nLen - 1));
      outIdx++;
    end
  end
  task automatic run(input string nm, input hdks_slot_t st, input logic pf, ct, en, sl, ps,
                     input logic [6:0] j);
    int p;
    int w;
    @(posedge clk_sys);
    slotType <= st;
    protectedFmt <= pf;
    tailIsCt <= ct;
    encryptOn <= en;
    slow <= sl;
    jLen <= j;
    frameStart <= 1'b1;
    nLen = (st == HDKS_DOUBLE) ? 868 : 148 + j;
    outIdx = 0;
    nDone = 0;
    @(posedge clk_sys);
    frameStart <= 1'b0;
    inValid <= 1'b1;
    inBit <= pat(0);
    p = 0;
    while (p < nLen) begin
      @(negedge clk_sys);
      w = inReady;
      @(posedge clk_sys);
      p = p + w;
      inBit <= pat(p);
    end
    inValid <= 1'b0;
    w = 0;
    @(negedge clk_sys);
    while (frameBusy && w < 50) begin
      @(negedge clk_sys);
      w++;
    end
    check("frameBusy", 11'(frameBusy), 11'h000);
    check("fieldDone", 11'(nDone), 11'h001);
    check("ksUsed", ksUsed, 11'(en ? ((st == HDKS_DOUBLE) ? 840 : 120 + j) : 0));
    check("outCount", 11'(outIdx), 11'(nLen));
    check("pairSecond", 11'(pairSecond), 11'(ps));
    $display("%s done", nm);
  endtask
  task automatic half_plain;
    run("half_plain", HDKS_HALF, 0, 1, 1, 1, 1, 7'h05);
  endtask
  task automatic half_prot;
    run("half_prot", HDKS_HALF, 1, 0, 1, 0, 0, 7'h03);
  endtask
  task automatic dbl_plain;
    run("dbl_plain", HDKS_DOUBLE, 0, 1, 1, 0, 1, 7'h00);
  endtask
  task automatic dbl_prot;
    run("dbl_prot", HDKS_DOUBLE, 1, 1, 1, 1, 0, 7'h00);
  endtask
  task automatic half_clear;
    run("half_clear", HDKS_HALF, 0, 1, 0, 0, 0, 7'h00);
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Longest run with stalls is about 1750 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    half_plain;
    half_prot;
    dbl_plain;
    dbl_prot;
    half_clear;
    give_verdict;
  end
endmodule
bind hdks_xor_core hdks_xor_core_sva u_sva (.clk_sys, .sys_rst, .frameStart, .slotType,
  .encryptOn, .jLen, .frameBusy, .inBit, .inValid, .inReady, .ksValid, .ksReady,
  .outBit, .fieldDone, .ksUsed);
